// [include/apd_if.sv]
/*
 * Carriers between the controller and its timer and refresh scheduler.
 * Assumes all parties share core_clk_in.
 */
`timescale 1ns/10ps
interface apd_tmr_if #(parameter int W = 16);
    logic load;
    logic [W-1:0] val;
    logic done;
    modport ctl(output load, output val, input done);
    modport tmr(input load, input val, output done);
endinterface

interface apd_ref_if;
    logic due;
    logic ack;
    modport src(output due, input ack);
    modport user(input due, output ack);
endinterface

// [include/apd_pkg.sv]
/*
 * Constants, state type and derived cycle counts for the page-mode
 * memory controller. Assumes a single 125 MHz clock domain.
 */
// Behaviour
// R1 - split address into row then column parts
// R2 - device latches row on row strobe fall
// R3 - hold row strobe low minimum active time
// R4 - wait row and column precharge before cycle
// R5 - write strobe high for reads, hold column
// R6 - read data valid after latest access limit
// R7 - write data valid by later strobe fall
// R8 - early write keeps data pins undriven
// R9 - device self-times write, next column early
// R10 - refresh all 512 rows every 8 ms
// R11 - every row-strobed cycle refreshes that row
// R12 - column-first refresh uses internal row counter
// R13 - column-first refresh keeps outputs undriven
// R14 - counter test: 512 writes then 512 reads
// R15 - page mode keeps row, any column accessible
// R16 - column buffer transparent until strobe falls
// R17 - mix reads and writes within open page
// R18 - row strobe gates data transfer
// R19 - column strobe gates data path, driver
// R20 - output gate switches driver only
// R21 - low write strobe disables output driver
// R22 - 200 us pause then eight row cycles
// R23 - late write strobe gives read/write cycle
// R24 - at least 110 ns between random cycles
// R25 - refresh every 15.6 us, ahead of accesses
package apd_pkg;
    localparam int ADDR_W = 18;
    localparam int COL_W = 9;
    localparam int DQ_W = 4;
    localparam int TMR_W = 16;
    localparam int AGE_W = 14;
    localparam int CLK_PS = 8000;
    localparam int T_RAS_NS = 60;
    localparam int T_RP_NS = 40;
    localparam int T_CP_NS = 10;
    localparam int T_RC_NS = 110;
    localparam int T_RAH_NS = 10;
    localparam int T_CAS_NS = 20;
    localparam int ACCESS_FROM_ROW_NS = 60;
    localparam int T_AR_NS = 50;
    localparam int T_CSR_NS = 5;
    localparam int T_CPT_NS = 40;
    localparam int T_REFI_NS = 15600;
    localparam int T_PWRUP_NS = 200000;
    localparam int T_RASP_NS = 100000;
    // least times round up, longest times round down
    localparam int RAS_CYC = (T_RAS_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int RP_CYC = (T_RP_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int CP_CYC = (T_CP_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int RC_CYC = (T_RC_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int RAH_CYC = (T_RAH_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int CAS_CYC = (T_CAS_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int RAC_CYC = (ACCESS_FROM_ROW_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int AR_CYC = (T_AR_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int CSR_CYC = (T_CSR_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int CPT_CYC = (T_CPT_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int REFI_CYC = (T_REFI_NS * 1000) / CLK_PS;
    localparam int PWRUP_CYC_DEF = (T_PWRUP_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int RASP_CYC_DEF = (T_RASP_NS * 1000) / CLK_PS;
    localparam int INIT_CYCLES = 8;
    localparam int ROWS = 512;
    typedef enum logic [3:0] {
        ST_PWR, ST_IDLE, ST_ROW, ST_COL, ST_CASLO, ST_PAGE,
        ST_PRE, ST_CBR_CAS, ST_CBR_RAS, ST_TST_CP
    } apd_state_type;
endpackage

// [rtl/apd_ctrl.sv]
/*
 * Host controller for a 256K x 4 page-mode dynamic memory: power-up,
 * column-first refresh, random and page accesses, counter test.
 * Assumes dq_in is synchronous to core_clk_in; pins drive the part.
 */
`timescale 1ns/10ps
module apd_ctrl
    import apd_pkg::*;
#(
    parameter int PWRUP_CYC = PWRUP_CYC_DEF,
    parameter int RASP_MAX_CYC = RASP_CYC_DEF,
    parameter int REF_INT_CYC = REFI_CYC
) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic req_valid_in,
    input wire logic req_write_in,
    input wire logic [ADDR_W-1:0] req_addr_in,
    input wire logic [DQ_W-1:0] req_wdata_in,
    input wire logic test_start_in,
    input wire logic [DQ_W-1:0] dq_in,
    output logic req_ready_out,
    output logic rd_valid_out,
    output logic [DQ_W-1:0] rd_data_out,
    output logic init_done_out,
    output logic test_busy_out,
    output logic test_fail_out,
    output logic ras_n_out,
    output logic cas_n_out,
    output logic we_n_out,
    output logic oe_n_out,
    output logic [COL_W-1:0] addr_out,
    output logic [DQ_W-1:0] dq_out,
    output logic dq_oe_out
);
    apd_tmr_if #(.W(TMR_W)) tmr ();
    apd_ref_if ref_i ();

    apd_timer #(.W(TMR_W), .RST_VAL(PWRUP_CYC)) u_tmr (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .t(tmr)
    );
    apd_refresh #(.INTERVAL(REF_INT_CYC)) u_ref (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .r(ref_i)
    );

    apd_state_type state_r, state_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic wr_r, wr_nxt;
    logic [DQ_W-1:0] wdata_r, wdata_nxt;
    logic [AGE_W-1:0] age_r, age_nxt;
    logic [3:0] init_r, init_nxt;
    logic tst_req_r, tst_req_nxt;
    logic tst_r, tst_nxt;
    logic tst_rd_r, tst_rd_nxt;
    logic [COL_W-1:0] idx_r, idx_nxt;
    logic fail_r, fail_nxt;
    logic rdv_r, rdv_nxt;
    logic [DQ_W-1:0] rdd_r, rdd_nxt;
    logic ras_n_r, ras_n_nxt, cas_n_r, cas_n_nxt;
    logic we_n_r, we_n_nxt, oe_n_r, oe_n_nxt;
    logic [COL_W-1:0] pa_r, pa_nxt;
    logic [DQ_W-1:0] dq_r, dq_nxt;
    logic dqe_r, dqe_nxt;
    logic row_hit, rasp_over, rd_ok, accept, row_open;
    int unsigned ph;

    assign row_hit = req_addr_in[ADDR_W-1:COL_W] == addr_r[ADDR_W-1:COL_W];
    assign rasp_over = age_r >= AGE_W'(RASP_MAX_CYC - RAS_CYC);
    // latest of row and column access limits; also column hold
    assign rd_ok = age_r >= AGE_W'(RAC_CYC - 1) && age_r >= AGE_W'(AR_CYC - 1); // [R6] [R5]
    // refresh and a queued test outrank pending accesses
    assign req_ready_out = (state_r == ST_IDLE && !ref_i.due && init_r == '0 && !tst_req_r)
        || (state_r == ST_PAGE && tmr.done && !ref_i.due && !rasp_over && !tst_req_r
        && row_hit); // [R25] [R15]
    assign accept = req_ready_out & req_valid_in;

    always_comb begin
        state_nxt = state_r;
        addr_nxt = addr_r;
        wr_nxt = wr_r;
        wdata_nxt = wdata_r;
        init_nxt = init_r;
        tst_req_nxt = tst_req_r | test_start_in;
        tst_nxt = tst_r;
        tst_rd_nxt = tst_rd_r;
        idx_nxt = idx_r;
        fail_nxt = fail_r;
        rdv_nxt = 1'b0;
        rdd_nxt = rdd_r;
        ref_i.ack = 1'b0;
        if (accept) begin
            // full 18-bit location held; row and column halves go out in turn
            addr_nxt = req_addr_in; // [R1]
            wr_nxt = req_write_in;
            wdata_nxt = req_wdata_in;
        end
        unique case (state_r)
            ST_PWR: begin
                if (tmr.done) state_nxt = ST_IDLE; // [R22]
            end
            ST_IDLE: begin
                if (ref_i.due || init_r != '0) begin
                    state_nxt = ST_CBR_CAS; // [R22] [R25]
                end else if (tst_req_r) begin
                    tst_req_nxt = test_start_in;
                    tst_nxt = 1'b1;
                    tst_rd_nxt = 1'b0;
                    idx_nxt = '0;
                    fail_nxt = 1'b0;
                    state_nxt = ST_CBR_CAS; // [R14]
                end else if (accept) begin
                    state_nxt = ST_ROW;
                end
            end
            ST_ROW: begin
                if (tmr.done) state_nxt = ST_COL;
            end
            ST_COL: begin
                if (tmr.done) state_nxt = ST_CASLO;
            end
            ST_CASLO: begin
                if (tmr.done && rd_ok) begin
                    if (!wr_r) begin
                        rdv_nxt = !tst_r;
                        rdd_nxt = dq_in;
                        if (tst_r && dq_in != wdata_r) fail_nxt = 1'b1; // [R14]
                    end
                    state_nxt = tst_r ? ST_PRE : ST_PAGE;
                end
            end
            ST_PAGE: begin
                if (tmr.done) begin
                    if (accept) begin
                        state_nxt = ST_COL; // [R15] [R17]
                    end else if (ref_i.due || rasp_over || tst_req_r || req_valid_in) begin
                        state_nxt = ST_PRE;
                    end
                end
            end
            ST_PRE: begin
                // row precharge covers the shorter column precharge too
                if (tmr.done && age_r >= AGE_W'(RC_CYC - 1)) begin // [R4] [R24]
                    state_nxt = ST_IDLE;
                    if (tst_r) begin
                        idx_nxt = idx_r + 1'b1;
                        if (idx_r == COL_W'(ROWS - 1)) begin
                            tst_rd_nxt = 1'b1;
                            tst_nxt = !tst_rd_r;
                        end
                        if (!(tst_rd_r && idx_r == COL_W'(ROWS - 1))) begin
                            state_nxt = ST_CBR_CAS;
                        end
                    end
                end
            end
            ST_CBR_CAS: begin
                if (tmr.done) state_nxt = ST_CBR_RAS;
            end
            ST_CBR_RAS: begin
                if (tmr.done) begin
                    ref_i.ack = 1'b1; // [R10]
                    if (init_r != '0) init_nxt = init_r - 1'b1; // [R22]
                    if (tst_r) begin
                        addr_nxt = {addr_r[ADDR_W-1:COL_W], idx_r};
                        wr_nxt = !tst_rd_r;
                        wdata_nxt = idx_r[DQ_W-1:0];
                        state_nxt = ST_TST_CP;
                    end else begin
                        state_nxt = ST_PRE;
                    end
                end
            end
            ST_TST_CP: begin
                if (tmr.done) state_nxt = ST_CASLO; // [R14]
            end
        endcase
    end

    always_comb begin
        ph = 1;
        unique case (state_nxt)
            ST_ROW: ph = RAH_CYC;
            ST_CASLO: ph = CAS_CYC;
            ST_PAGE: ph = CP_CYC;
            ST_PRE: ph = RP_CYC;
            ST_CBR_CAS: ph = CSR_CYC;
            ST_CBR_RAS: ph = RAS_CYC; // [R3]
            ST_TST_CP: ph = CPT_CYC;
            default: ph = 1;
        endcase
        tmr.load = state_nxt != state_r;
        tmr.val = TMR_W'(ph - 1);
    end

    // pins decoded from the next state so they leave flops aligned with it
    always_comb begin
        row_open = state_nxt inside {ST_ROW, ST_COL, ST_CASLO, ST_PAGE, ST_CBR_RAS, ST_TST_CP};
        ras_n_nxt = !row_open; // [R18]
        // column-first order marks a refresh; address pins are don't-care
        cas_n_nxt = !(state_nxt inside {ST_CASLO, ST_CBR_CAS, ST_CBR_RAS}); // [R12] [R19]
        // write strobe low before column strobe: early write, pins stay undriven
        we_n_nxt = !(wr_nxt && state_nxt inside {ST_COL, ST_CASLO, ST_TST_CP}); // [R5] [R7] [R21]
        // output gate only low on reads, so it never fights write data
        oe_n_nxt = !(state_nxt == ST_CASLO && !wr_nxt); // [R8] [R20]
        dqe_nxt = wr_nxt && state_nxt inside {ST_COL, ST_CASLO, ST_TST_CP}; // [R7] [R13]
        dq_nxt = wdata_nxt;
        pa_nxt = addr_nxt[COL_W-1:0]; // [R16] [R9]
        if (state_nxt == ST_ROW) pa_nxt = addr_nxt[ADDR_W-1:COL_W]; // [R1]
        age_nxt = (age_r == '1) ? age_r : age_r + 1'b1;
        if (state_nxt != state_r && state_nxt inside {ST_ROW, ST_CBR_RAS}) age_nxt = '0;
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            state_r <= ST_PWR;
            addr_r <= '0;
            wr_r <= 1'b0;
            wdata_r <= '0;
            age_r <= '1;
            init_r <= 4'(INIT_CYCLES);
            tst_req_r <= 1'b0;
            tst_r <= 1'b0;
            tst_rd_r <= 1'b0;
            idx_r <= '0;
            fail_r <= 1'b0;
            rdv_r <= 1'b0;
            rdd_r <= '0;
            ras_n_r <= 1'b1;
            cas_n_r <= 1'b1;
            we_n_r <= 1'b1;
            oe_n_r <= 1'b1;
            pa_r <= '0;
            dq_r <= '0;
            dqe_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            addr_r <= addr_nxt;
            wr_r <= wr_nxt;
            wdata_r <= wdata_nxt;
            age_r <= age_nxt;
            init_r <= init_nxt;
            tst_req_r <= tst_req_nxt;
            tst_r <= tst_nxt;
            tst_rd_r <= tst_rd_nxt;
            idx_r <= idx_nxt;
            fail_r <= fail_nxt;
            rdv_r <= rdv_nxt;
            rdd_r <= rdd_nxt;
            ras_n_r <= ras_n_nxt;
            cas_n_r <= cas_n_nxt;
            we_n_r <= we_n_nxt;
            oe_n_r <= oe_n_nxt;
            pa_r <= pa_nxt;
            dq_r <= dq_nxt;
            dqe_r <= dqe_nxt;
        end
    end

    assign rd_valid_out = rdv_r;
    assign rd_data_out = rdd_r;
    assign init_done_out = (init_r == '0) && state_r != ST_PWR;
    assign test_busy_out = tst_r | tst_req_r;
    assign test_fail_out = fail_r;
    assign ras_n_out = ras_n_r;
    assign cas_n_out = cas_n_r;
    assign we_n_out = we_n_r;
    assign oe_n_out = oe_n_r;
    assign addr_out = pa_r;
    assign dq_out = dq_r;
    assign dq_oe_out = dqe_r;

    // helper: cycles the row strobe has been high
    logic [AGE_W-1:0] hi_r;
    always_ff @(posedge core_clk_in) begin
        if (rst_in) hi_r <= '0;
        else hi_r <= ras_n_r ? ((hi_r == '1) ? hi_r : hi_r + 1'b1) : '0;
    end

    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    a_ras_min_low: assert property ($rose(ras_n_out) |-> $past(age_r) >= RAS_CYC - 1) // [R3]
        else $error("row strobe low too short");
    a_ras_precharge: assert property ($fell(ras_n_out) |-> $past(hi_r) >= RP_CYC - 1) // [R4]
        else $error("row precharge too short");
    a_rc_spacing: assert property ($fell(ras_n_out) |-> $past(age_r) >= RC_CYC - 1) // [R24]
        else $error("random cycle too short");
    a_read_we_high: assert property (!ras_n_out && !oe_n_out |-> we_n_out) // [R5]
        else $error("write strobe low in read");
    a_write_data: assert property (!cas_n_out && !we_n_out |-> dq_oe_out && oe_n_out) // [R7]
        else $error("write data not driven");
    a_drive_gate: assert property (dq_oe_out |-> oe_n_out && !we_n_out) // [R8]
        else $error("driving data with gate low");
    a_cbr_undriven: assert property ($fell(ras_n_out) && !cas_n_out |-> !dq_oe_out [*2]) // [R13]
        else $error("data driven in refresh");
    a_row_address: assert property ($fell(ras_n_out) && cas_n_out
        |-> addr_out == addr_r[ADDR_W-1:COL_W]) // [R1]
        else $error("row address wrong");
    a_ref_first: assert property (state_r == ST_IDLE && ref_i.due |-> !req_ready_out) // [R25]
        else $error("access taken over refresh");
    a_pwr_quiet: assert property (state_r == ST_PWR |-> ras_n_out && cas_n_out) // [R22]
        else $error("strobes active in power-up pause");

    c_page_hit: cover property (!ras_n_out && $fell(cas_n_out) ##[1:40] $fell(cas_n_out)
        && !ras_n_out);
    c_read: cover property (rd_valid_out);
    c_cbr: cover property (!cas_n_out && $fell(ras_n_out));
    c_test_end: cover property ($fell(test_busy_out));
endmodule

// [rtl/apd_refresh.sv]
/*
 * Refresh interval scheduler: raises due every interval until acked.
 * Assumes the controller acks once per completed refresh cycle.
 */
`timescale 1ns/10ps
module apd_refresh
    import apd_pkg::*;
#(
    parameter int INTERVAL = REFI_CYC
) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    apd_ref_if.src r
);
    logic [TMR_W-1:0] cnt_r;
    logic [TMR_W-1:0] cnt_nxt;
    logic due_r;
    logic due_nxt;
    logic tick;

    always_comb begin
        tick = (cnt_r == '0);
        cnt_nxt = tick ? TMR_W'(INTERVAL - 1) : cnt_r - 1'b1;
        // a tick in the ack cycle is kept
        due_nxt = tick | (due_r & ~r.ack); // [R25]
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            // first interval follows the parameter, not the package default
            cnt_r <= TMR_W'(INTERVAL - 1);
            due_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            due_r <= due_nxt;
        end
    end

    assign r.due = due_r;

    a_due_on_tick: assert property (@(posedge core_clk_in) disable iff (rst_in)
        tick |=> due_r) else $error("refresh tick lost"); // [R10]
endmodule

// [rtl/apd_timer.sv]
/*
 * Down counter timing each strobe phase; done at zero.
 * Assumes load arrives with the cycle count minus one.
 */
`timescale 1ns/10ps
module apd_timer
    import apd_pkg::*;
#(
    parameter int W = 16,
    parameter int RST_VAL = 0
) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    apd_tmr_if.tmr t
);
    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        if (t.load) begin
            cnt_nxt = t.val;
        end else if (cnt_r != '0) begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            cnt_r <= W'(RST_VAL);
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign t.done = (cnt_r == '0);
endmodule

// [tb/apd_mem_model.sv]
/*
 * Behavioural model of the 256K x 4 page-mode memory on the far side.
 * Assumes strobes and data come from the controller pins; no clock of its own.
 */
`timescale 1ns/10ps
module apd_mem_model
    import apd_pkg::*;
(
    input wire logic ras_n_in,
    input wire logic cas_n_in,
    input wire logic we_n_in,
    input wire logic oe_n_in,
    input wire logic [COL_W-1:0] addr_in,
    input wire logic [DQ_W-1:0] dq_drv_in,
    input wire logic dq_oe_in,
    input wire logic corrupt_in,
    output logic [DQ_W-1:0] dq_out,
    output int ras_falls_out,
    output int cbr_out,
    output int viol_out,
    output logic [COL_W-1:0] row_out,
    output logic [COL_W-1:0] col_out
);
    localparam realtime CAC_NS = 20;
    logic [DQ_W-1:0] mem [0:(1<<ADDR_W)-1];
    logic [COL_W-1:0] cnt = '0;
    logic act = 1'b0;
    logic drv;
    realtime t_rf = -1000;
    realtime t_rr = -1000;
    realtime t_cf = 0;
    initial begin
        ras_falls_out = 0;
        cbr_out = 0;
        viol_out = 0;
    end
    always @(negedge ras_n_in) begin
        if (($realtime - t_rr) < T_RP_NS || ($realtime - t_rf) < T_RC_NS) viol_out++;
        t_rf = $realtime;
        ras_falls_out++;
        if (!cas_n_in) begin
            row_out = cnt;
            cnt++;
            cbr_out++;
        end else begin
            row_out = addr_in;
        end
    end
    always @(posedge ras_n_in) begin
        if (($realtime - t_rf) < T_RAS_NS) viol_out++;
        t_rr = $realtime;
        act = 1'b0;
    end
    // column latch and write in one block so the write sees the new column
    always @(negedge cas_n_in) begin
        if (!ras_n_in) begin
            act = 1'b1;
            col_out = addr_in;
            t_cf = $realtime;
            if (!we_n_in) mem[{row_out, col_out}] = dq_drv_in;
        end
    end
    // late write: pins showed the old cell data until the write strobe fell
    always @(negedge we_n_in) begin
        if (act) mem[{row_out, col_out}] = dq_drv_in;
    end
    always @(posedge cas_n_in) act = 1'b0;
    // evaluated off the clock edges; released pins show a changing value
    initial begin
        dq_out = '0;
        #0.5;
        forever begin
            drv = act && !oe_n_in && we_n_in && ($realtime - t_cf) >= CAC_NS
                && ($realtime - t_rf) >= ACCESS_FROM_ROW_NS;
            dq_out = drv ? mem[{row_out, col_out}] ^ {DQ_W{corrupt_in}} : ~dq_out;
            if (drv && dq_oe_in) viol_out++;
            #1;
        end
    end
endmodule

// [tb/async_page_mode_dram_core_tb_top.sv]
/*
 * Self-checking bench for the page-mode memory controller.
 * Assumes the memory model on the pins; inputs change at the falling edge.
 */
`timescale 1ns/10ps
module async_page_mode_dram_core_tb_top;
    import apd_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic valid = 1'b0;
    logic wr = 1'b0;
    logic tst = 1'b0;
    logic corrupt = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic [DQ_W-1:0] wdata = '0;
    logic [DQ_W-1:0] dq_in, rdata, dq_o, q;
    logic ready, rdv, idone, busy, tfail, ras_n, cas_n, we_n, oe_n, dq_oe;
    logic [COL_W-1:0] a_pin, row, col;
    int falls, cbr, viol;
    int failures = 0;
    int comparisons = 0;
    apd_ctrl #(.PWRUP_CYC(20), .RASP_MAX_CYC(40), .REF_INT_CYC(200)) i_dut (
        .core_clk_in(clk), .rst_in(rst), .req_valid_in(valid), .req_write_in(wr),
        .req_addr_in(addr), .req_wdata_in(wdata), .test_start_in(tst), .dq_in(dq_in),
        .req_ready_out(ready), .rd_valid_out(rdv), .rd_data_out(rdata),
        .init_done_out(idone), .test_busy_out(busy), .test_fail_out(tfail),
        .ras_n_out(ras_n), .cas_n_out(cas_n), .we_n_out(we_n), .oe_n_out(oe_n),
        .addr_out(a_pin), .dq_out(dq_o), .dq_oe_out(dq_oe));
    apd_mem_model i_mem (
        .ras_n_in(ras_n), .cas_n_in(cas_n), .we_n_in(we_n), .oe_n_in(oe_n),
        .addr_in(a_pin), .dq_drv_in(dq_o), .dq_oe_in(dq_oe), .corrupt_in(corrupt),
        .dq_out(dq_in), .ras_falls_out(falls), .cbr_out(cbr), .viol_out(viol),
        .row_out(row), .col_out(col));
    initial begin
        forever #4 clk = ~clk;
    end
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic test_done;
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic timeout(input int n, input int lim);
        if (n > lim) begin
            failures++;
            $display("[FAIL] wait expected done seen timeout");
            test_done();
        end
    endtask
    // one request held until taken; reads wait for the data pulse
    task automatic acc(input logic w, input logic [ADDR_W-1:0] a, input logic [DQ_W-1:0] d);
        int n;
        @(negedge clk);
        valid = 1'b1;
        wr = w;
        addr = a;
        wdata = d;
        n = 0;
        @(posedge clk);
        while (ready !== 1'b1) begin
            n++;
            timeout(n, 2000);
            @(posedge clk);
        end
        @(negedge clk);
        valid = 1'b0;
        n = 0;
        while (!w && rdv !== 1'b1) begin
            @(negedge clk);
            n++;
            timeout(n, 100);
        end
        q = rdata;
    endtask
    task automatic s_init;
        int n;
        int hi;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        hi = 0;
        for (n = 0; n < 20; n++) begin
            @(negedge clk);
            if (ras_n === 1'b1) hi++;
        end
        chk("pause", 20, hi);
        n = 0;
        while (idone !== 1'b1) begin
            @(negedge clk);
            n++;
            timeout(n, 1000);
        end
        chk("init cbr", 8, cbr);
        chk("init falls", 8, falls);
    endtask
    task automatic s_page;
        int f0;
        int c0;
        f0 = falls;
        c0 = cbr;
        acc(1'b1, 18'h2A5C3, 4'h5);
        acc(1'b1, 18'h2A5C4, 4'hA);
        acc(1'b0, 18'h2A5C3, 4'h0);
        chk("rd col a", 4'h5, q);
        chk("row pins", 9'h152, row);
        chk("col pins", 9'h1C3, col);
        acc(1'b0, 18'h2A5C4, 4'h0);
        chk("rd col b", 4'hA, q);
        chk("page kept", 1, (falls - f0) - (cbr - c0) <= 1 + (cbr - c0));
    endtask
    task automatic s_rows;
        acc(1'b1, 18'h0F0A1, 4'h3);
        acc(1'b0, 18'h2A5C3, 4'h0);
        chk("rd row a", 4'h5, q);
        acc(1'b0, 18'h0F0A1, 4'h0);
        chk("rd row b", 4'h3, q);
        chk("row b pins", 9'h078, row);
    endtask
    task automatic s_ref;
        int c0;
        c0 = cbr;
        repeat (450) @(negedge clk);
        chk("refresh due", 1, cbr - c0 >= 2);
        chk("dq idle", 0, dq_oe);
    endtask
    task automatic s_test(input logic bad);
        int n;
        int c0;
        c0 = cbr;
        @(negedge clk);
        corrupt = bad;
        tst = 1'b1;
        @(negedge clk);
        tst = 1'b0;
        n = 0;
        while (busy !== 1'b0 || n < 2) begin
            @(negedge clk);
            n++;
            timeout(n, 60000);
        end
        chk("test fail", bad, tfail);
        chk("test cycles", 1, cbr - c0 >= 1024);
        corrupt = 1'b0;
    endtask
    initial begin
        s_init();
        s_page();
        s_rows();
        s_ref();
        s_test(1'b1);
        s_test(1'b0);
        // counter test pattern wrote one cell in each of the 512 rows, rows taken from the model's internal row counter
        s_page();
        s_rows();
        chk("pin timing", 0, viol);
        test_done();
    end
endmodule
